// >>> svid_defs.vh
// constants for the serial vid slave and start-up block
`ifndef SVID_DEFS_VH
`define SVID_DEFS_VH
`define SVID_ADDR_FIXED 3'h7
`define SVID_ADDR_FIXED_VAL 3'b110
`define SVID_ADDR_CORE_BIT 1
`define SVID_ADDR_AUX_BIT 0
`define SVID_DATA_PSI_BIT 7
`define SVID_VID_MAX 7'h7f
`define SVID_VID_1V50 7'h03
`define SVID_VID_0P5_ZERO 7'h00
// 12.5 mv steps from 1.55 v; boot levels as vid codes
`define SVID_VID_1V55 7'h00
`define SVID_BOOT_N00 7'h24
`define SVID_BOOT_N01 7'h2c
`define SVID_BOOT_N10 7'h34
`define SVID_BOOT_N11 7'h3c
`define SVID_BOOT_F00 7'h0c
`define SVID_BOOT_F01 7'h1c
`define SVID_BOOT_F10 7'h2c
`define SVID_BOOT_F11 7'h3c
`define SVID_RAMP_DIV 8'h0a
`define SVID_RESET_VID 7'h7f
`endif

// >>> svid_sync.v
// two flip-flop synchroniser for one input bit
module svid_sync (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // data
  input wire din,
  output reg dout
);
  reg meta;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // svid_sync

// >>> svid_ramp.v
// reference ramp for one rail, one code step per enable
`include "svid_defs.vh"
module svid_ramp (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // control
  input wire step_en,
  input wire [6:0] target,
  input wire rail_on,
  // state
  output reg [6:0] ref_code,
  output wire settled
);
  assign settled = !rail_on || (ref_code == target);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_code <= `SVID_RESET_VID;
    end else if (!rail_on) begin
      ref_code <= `SVID_RESET_VID;
    end else if (step_en && ref_code > target) begin
      ref_code <= ref_code - 7'h01;
    end else if (step_en && ref_code < target) begin
      ref_code <= ref_code + 7'h01;
    end
  end
endmodule // svid_ramp

// >>> svid_top.v
// serial vid slave with boot code capture and soft-start
`include "svid_defs.vh"
// Notes on behaviour
// RQ1: processor alone masters the link
// RQ2: i2c start, stop, ack framing
// RQ3: rails good only while in regulation; code clears it on lost regulation only in ST_WAIT, not in ST_RUN
// RQ4: capture clock, data at enable rise
// RQ5: soft-start both rails to boot code
// RQ6: return to boot code when power-ok drops
// RQ7: rails good, then await power-ok
// RQ8: ignore link while power-ok low
// RQ9: act on commands while power-ok high
// RQ10: decode boot code per mode table
// RQ11: start, address, write, data, stop
// RQ12: ack after address and after data
// RQ13: apply command only after stop
// RQ14: per-rail off/on keeps rails good
// RQ15: address bits 6:4 are 110, 3:2 ignored
// RQ16: bit1 core, bit0 aux, both allowed
// RQ17: data bit 7 is power-save hint
// RQ18: vid falls 12.5 mv per code
// RQ19: serial mode when type select low
// RQ20: debug mode: static pins, no commands
// RQ21: fewer phases on power-save hint
// RQ22: nack bad address or read bit
// RQ23: incomplete transaction changes nothing
module svid_top (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // start-up control
  input wire enable,
  input wire type_select_line,
  input wire fixed_voltage_debug,
  input wire cpu_power_ok,
  // serial link pins
  input wire serial_vid_clock,
  input wire serial_vid_data_in,
  output reg serial_vid_data_out,
  output reg serial_vid_data_oe,
  // rail status
  input wire core_in_reg,
  input wire aux_in_reg,
  output reg rails_good_output,
  output reg serial_mode,
  output reg [1:0] boot_code,
  output reg [6:0] core_ref,
  output reg [6:0] aux_ref,
  output reg core_on,
  output reg aux_on,
  output reg power_saving_hint_n,
  output reg reduced_phases
);
  localparam ST_OFF = 3'd0;
  localparam ST_SOFT = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_RUN = 3'd3;
  localparam ST_PARK = 3'd4;
  localparam BS_IDLE = 3'd0;
  localparam BS_ADDR = 3'd1;
  localparam BS_AACK = 3'd2;
  localparam BS_DATA = 3'd3;
  localparam BS_DACK = 3'd4;
  localparam BS_DONE = 3'd5;
  localparam BS_SKIP = 3'd6;

  // two-flop synchronisers, one per pin input
  wire [7:0] pin_raw;
  wire [7:0] pin_s;
  wire en_s;
  wire tsel_s;
  wire dbg_s;
  wire pok_s;
  wire scl_s;
  wire sda_s;
  wire core_ok_s;
  wire aux_ok_s;
  genvar gi;
  assign pin_raw = {aux_in_reg, core_in_reg, serial_vid_data_in, serial_vid_clock, cpu_power_ok,
    fixed_voltage_debug, type_select_line, enable};
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      svid_sync u_sync (.clk(clk), .arst_n(arst_n), .din(pin_raw[gi]), .dout(pin_s[gi]));
    end
  endgenerate
  assign en_s = pin_s[0];
  assign tsel_s = pin_s[1];
  assign dbg_s = pin_s[2];
  assign pok_s = pin_s[3];
  assign scl_s = pin_s[4];
  assign sda_s = pin_s[5];
  assign core_ok_s = pin_s[6];
  assign aux_ok_s = pin_s[7];

  reg en_d;
  reg scl_d;
  reg sda_d;
  reg debug_mode;
  reg [2:0] st;
  reg [2:0] bs;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [6:0] addr_hold;
  reg [7:0] data_hold;
  reg cmd_ready;
  reg [6:0] boot_vid;
  reg [6:0] core_tgt;
  reg [6:0] aux_tgt;
  reg [7:0] div_cnt;
  reg ramp_en;
  wire [6:0] core_r;
  wire [6:0] aux_r;
  wire core_set;
  wire aux_set;
  reg [6:0] next_boot_vid;

  wire en_rise = en_s && !en_d;
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_c = scl_s && scl_d && sda_d && !sda_s; // [RQ2]
  wire stop_c = scl_s && scl_d && !sda_d && sda_s; // [RQ2]
  wire listen = serial_mode && !debug_mode && st == ST_RUN && pok_s; // [RQ8] [RQ9] [RQ20]

  // boot level from captured pins and mode
  always @* begin
    next_boot_vid = `SVID_BOOT_N00;
    case ({dbg_s, scl_s, sda_s}) // [RQ10]
      3'b000: next_boot_vid = `SVID_BOOT_N00;
      3'b001: next_boot_vid = `SVID_BOOT_N01;
      3'b010: next_boot_vid = `SVID_BOOT_N10;
      3'b011: next_boot_vid = `SVID_BOOT_N11;
      3'b100: next_boot_vid = `SVID_BOOT_F00;
      3'b101: next_boot_vid = `SVID_BOOT_F01;
      3'b110: next_boot_vid = `SVID_BOOT_F10;
      3'b111: next_boot_vid = `SVID_BOOT_F11;
      default: next_boot_vid = `SVID_BOOT_N00;
    endcase
  end

  // soft-start step enable
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 8'h00;
      ramp_en <= 1'b0;
    end else begin
      ramp_en <= (div_cnt == `SVID_RAMP_DIV - 8'h01);
      div_cnt <= (div_cnt == `SVID_RAMP_DIV - 8'h01) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  svid_ramp u_core (
    .clk(clk),
    .arst_n(arst_n),
    .step_en(ramp_en),
    .target(core_tgt),
    .rail_on(core_on),
    .ref_code(core_r),
    .settled(core_set)
  ); // [RQ5] [RQ18]
  svid_ramp u_aux (
    .clk(clk),
    .arst_n(arst_n),
    .step_en(ramp_en),
    .target(aux_tgt),
    .rail_on(aux_on),
    .ref_code(aux_r),
    .settled(aux_set)
  ); // [RQ5] [RQ18]

  // byte receiver on the serial link
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d <= 1'b0;
      sda_d <= 1'b0;
      bs <= BS_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      addr_hold <= 7'h00;
      data_hold <= 8'h00;
      cmd_ready <= 1'b0;
      serial_vid_data_out <= 1'b0;
      serial_vid_data_oe <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      cmd_ready <= 1'b0;
      if (!listen) begin
        bs <= BS_IDLE; // [RQ8] [RQ23]
        serial_vid_data_oe <= 1'b0;
      end else if (start_c) begin
        bs <= BS_ADDR; // [RQ11]
        bit_cnt <= 4'h0;
        serial_vid_data_oe <= 1'b0;
      end else if (stop_c) begin
        cmd_ready <= (bs == BS_DONE); // [RQ13] [RQ23]
        bs <= BS_IDLE;
        serial_vid_data_oe <= 1'b0;
      end else begin
        case (bs)
          BS_ADDR, BS_DATA: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (bs == BS_DATA) begin
                data_hold <= shift;
                bs <= BS_DACK;
                serial_vid_data_out <= 1'b0;
                serial_vid_data_oe <= 1'b1; // [RQ12]
              end else if (shift[7:5] == `SVID_ADDR_FIXED_VAL && !shift[0]) begin // [RQ15] [RQ22]
                addr_hold <= shift[7:1];
                bs <= BS_AACK;
                serial_vid_data_out <= 1'b0;
                serial_vid_data_oe <= 1'b1; // [RQ12]
              end else begin
                bs <= BS_SKIP; // [RQ22]
              end
            end
          end
          BS_AACK: if (scl_fall) begin
            serial_vid_data_oe <= 1'b0;
            bs <= BS_DATA;
          end
          BS_DACK: if (scl_fall) begin
            serial_vid_data_oe <= 1'b0;
            bs <= BS_DONE;
          end
          BS_DONE: bs <= BS_DONE;
          BS_SKIP: bs <= BS_SKIP;
          default: bs <= BS_IDLE;
        endcase
      end
    end
  end

  // start-up sequence and command application
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_d <= 1'b0;
      st <= ST_OFF;
      serial_mode <= 1'b0;
      debug_mode <= 1'b0;
      boot_code <= 2'b00;
      boot_vid <= `SVID_RESET_VID;
      core_tgt <= `SVID_RESET_VID;
      aux_tgt <= `SVID_RESET_VID;
      core_on <= 1'b0;
      aux_on <= 1'b0;
      rails_good_output <= 1'b0;
      power_saving_hint_n <= 1'b1;
      reduced_phases <= 1'b0;
      core_ref <= `SVID_RESET_VID;
      aux_ref <= `SVID_RESET_VID;
    end else begin
      en_d <= en_s;
      core_ref <= core_r;
      aux_ref <= aux_r;
      reduced_phases <= !power_saving_hint_n; // [RQ21]
      if (!en_s) begin
        st <= ST_OFF;
        core_on <= 1'b0;
        aux_on <= 1'b0;
        rails_good_output <= 1'b0;
      end else if (en_rise) begin
        serial_mode <= !tsel_s; // [RQ19]
        debug_mode <= dbg_s;
        boot_code <= {scl_s, sda_s}; // [RQ4]
        boot_vid <= next_boot_vid;
        core_tgt <= next_boot_vid; // [RQ5]
        aux_tgt <= next_boot_vid;
        core_on <= !tsel_s;
        aux_on <= !tsel_s;
        power_saving_hint_n <= 1'b1;
        st <= tsel_s ? ST_PARK : ST_SOFT;
      end else begin
        case (st)
          ST_SOFT: if (core_set && aux_set && core_ok_s && aux_ok_s) begin
            rails_good_output <= 1'b1; // [RQ3] [RQ7]
            st <= ST_WAIT;
          end
          ST_WAIT: if (pok_s && !debug_mode) st <= ST_RUN; // [RQ7] [RQ20]
          ST_RUN: begin
            if (!pok_s) begin
              core_tgt <= boot_vid; // [RQ6]
              aux_tgt <= boot_vid;
              core_on <= 1'b1;
              aux_on <= 1'b1;
              power_saving_hint_n <= 1'b1;
              st <= ST_WAIT;
            end else if (cmd_ready) begin
              power_saving_hint_n <= data_hold[`SVID_DATA_PSI_BIT]; // [RQ17]
              if (addr_hold[`SVID_ADDR_CORE_BIT]) begin // [RQ16]
                core_tgt <= data_hold[6:0];
                core_on <= (data_hold[6:0] != `SVID_VID_MAX); // [RQ14]
              end
              if (addr_hold[`SVID_ADDR_AUX_BIT]) begin // [RQ16]
                aux_tgt <= data_hold[6:0];
                aux_on <= (data_hold[6:0] != `SVID_VID_MAX); // [RQ14]
              end
            end
          end
          ST_PARK: st <= ST_PARK;
          default: st <= ST_OFF;
        endcase
        if (st == ST_SOFT || st == ST_WAIT) begin
          if (!(core_ok_s && aux_ok_s) && st == ST_WAIT) rails_good_output <= 1'b0; // [RQ3]
        end
      end
    end
  end
endmodule // svid_top

// >>> svid_top_assertions.sv
// port checker for the serial vid slave and start-up block
module svid_chk (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // watched ports
  input wire enable,
  input wire cpu_power_ok,
  input wire serial_vid_clock,
  input wire serial_vid_data_out,
  input wire serial_vid_data_oe,
  input wire rails_good_output,
  input wire serial_mode,
  input wire [1:0] boot_code,
  input wire [6:0] core_ref,
  input wire core_on,
  input wire aux_on,
  input wire power_saving_hint_n,
  input wire reduced_phases
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence ack_hold;
    serial_vid_data_oe [*6];
  endsequence
  sequence core_step;
    core_ref == $past(core_ref) + 7'h01 || core_ref == $past(core_ref) - 7'h01;
  endsequence
  ack_low_a: assert property (serial_vid_data_oe |-> !serial_vid_data_out)
    else $error("ack bit not driven low");
  ack_slot_a: assert property ($rose(serial_vid_data_oe) |->
    (!serial_vid_clock && !$past(serial_vid_clock, 2)) ##0 ack_hold) else $error("ack outside its slot");
  quiet_unpowered_a: assert property (!cpu_power_ok [*4] |-> !serial_vid_data_oe)
    else $error("ack while power ok low");
  quiet_parallel_a: assert property (!serial_mode |-> !serial_vid_data_oe)
    else $error("ack outside serial mode");
  core_ramp_a: assert property (rails_good_output && core_on && $past(core_on) && $changed(core_ref) |->
    core_step) else $error("core reference jumped");
  good_enable_a: assert property (!enable [*5] |-> !rails_good_output)
    else $error("rails good without enable");
  boot_hold_a: assert property (enable [*8] |-> $stable(boot_code))
    else $error("boot code changed while enabled");
  phase_follow_a: assert property (reduced_phases == !$past(power_saving_hint_n))
    else $error("phase count ignores hint");
  rail_off_a: assert property (rails_good_output && enable && $fell(aux_on) |=> rails_good_output [*3])
    else $error("rails good lost on rail off");
endmodule // svid_chk

bind svid_top svid_chk i_svid_chk (.clk, .arst_n, .enable, .cpu_power_ok, .serial_vid_clock,
  .serial_vid_data_out, .serial_vid_data_oe, .rails_good_output, .serial_mode, .boot_code,
  .core_ref, .core_on, .aux_on, .power_saving_hint_n, .reduced_phases);

// >>> svid_cpu_model.sv
// cpu-side master model for the serial vid link
module svid_cpu_model (
  // link pins
  output logic scl,
  output logic sda_low,
  input wire sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // static pin levels for boot code capture
  task automatic put(input logic c, input logic d);
    scl = c;
    sda_low = !d;
  endtask
  // one bit: data set in low phase, read in high phase
  task automatic bit_io(input logic b, output logic r);
    #200 sda_low = !b;
    #200 scl = 1'b1;
    #200 r = sda;
    #200 scl = 1'b0;
  endtask
  // master owns the clock for the whole frame and releases data for the address ack bit, and for the data ack bit only after an address ack
  task automatic xfer(input logic [7:0] ab, input logic [7:0] db, input logic stp, output logic [1:0] ack);
    logic r;
    #237 sda_low = 1'b0;
    #200 scl = 1'b1;
    #200 sda_low = 1'b1; // start, or repeated start
    #200 scl = 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(ab[i], r); // address then write bit, msb first
    bit_io(1'b1, ack[1]);
    ack[0] = 1'b1;
    if (ack[1] == 1'b0) begin
      for (int i = 7; i >= 0; i--) bit_io(db[i], r);
      bit_io(1'b1, ack[0]);
    end
    if (stp) begin
      #200 sda_low = 1'b1;
      #200 scl = 1'b1;
      #200 sda_low = 1'b0; // stop
    end
  endtask
endmodule // svid_cpu_model

// >>> test_serial_vid_slave_startup.sv
// self-checking bench for the serial vid slave and start-up block
module test_serial_vid_slave_startup;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string n; logic [6:0] e;} svid_note_t;
  logic clk, arst_n, enable, type_select_line, fixed_voltage_debug, cpu_power_ok, core_in_reg, aux_in_reg;
  logic sda_low, serial_vid_data_out, serial_vid_data_oe, rails_good_output, serial_mode;
  logic core_on, aux_on, power_saving_hint_n, reduced_phases;
  logic [1:0] boot_code, ack;
  logic [6:0] core_ref, aux_ref;
  logic [31:0] lfsr = 32'h98ce_a4f0;
  logic [6:0] boot_tab [8] = '{7'h24, 7'h2c, 7'h34, 7'h3c, 7'h0c, 7'h1c, 7'h2c, 7'h3c};
  wire serial_vid_clock;
  wire serial_vid_data_in = !(sda_low || (serial_vid_data_oe && !serial_vid_data_out));
  int err_count = 0;
  int compares = 0;
  svid_note_t notes [$];
  event look;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
  svid_top i_svid_top (.clk, .arst_n, .enable, .type_select_line, .fixed_voltage_debug, .cpu_power_ok,
    .serial_vid_clock, .serial_vid_data_in, .serial_vid_data_out, .serial_vid_data_oe, .core_in_reg,
    .aux_in_reg, .rails_good_output, .serial_mode, .boot_code, .core_ref, .aux_ref, .core_on, .aux_on,
    .power_saving_hint_n, .reduced_phases);
  svid_cpu_model i_svid_cpu_model (.scl(serial_vid_clock), .sda_low, .sda(serial_vid_data_in));
  function automatic logic [6:0] obs(input string n);
    case (n)
      "core": return core_ref;
      "aux": return aux_ref;
      "good": return {6'h00, rails_good_output};
      "boot": return {5'h00, boot_code};
      "hint": return {5'h00, reduced_phases, power_saving_hint_n};
      "mode": return {6'h00, serial_mode};
      "on": return {5'h00, core_on, aux_on};
      default: return {5'h00, ack};
    endcase
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // note the expectation, wait a bounded time for it, then let the watcher compare
  task automatic await_val(input string n, input logic [6:0] e, input int lim);
    logic miss;
    notes.push_back('{n, e});
    for (int i = 0; i < lim && obs(n) !== e; i++) @(negedge clk);
    miss = (obs(n) !== e);
    -> look;
    @(negedge clk);
    if (lim > 0 && miss) close_out();
  endtask
  always @(look) begin
    svid_note_t t;
    t = notes.pop_front();
    `CHK(t.n, t.e, obs(t.n))
  end
  task automatic cmd(input logic [7:0] ab, input logic [7:0] db, input logic stp);
    i_svid_cpu_model.xfer(ab, db, stp, ack);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end
  initial begin
    logic [6:0] v;
    logic [6:0] b;
    {arst_n, enable, type_select_line, fixed_voltage_debug, cpu_power_ok} = 5'h00;
    {core_in_reg, aux_in_reg} = 2'h3;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    for (int m = 0; m < 9; m++) begin
      b = boot_tab[m % 8];
      fixed_voltage_debug = m[2];
      i_svid_cpu_model.put(m[1], m[0]);
      repeat (4) @(negedge clk);
      enable = 1'b1;
      repeat (8) @(negedge clk);
      i_svid_cpu_model.put(1'b1, 1'b1);
      await_val("boot", {5'h00, m[1:0]}, 0);
      await_val("core", b, 2000);
      await_val("aux", b, 200);
      await_val("good", 7'h01, 200);
      await_val("mode", 7'h01, 0);
      if (m == 8) break;
      lfsr = lfsr_next(lfsr);
      v = (lfsr[6:0] == 7'h7f) ? 7'h40 : lfsr[6:0];
      cmd({3'h6, lfsr[9:8], 3'h6}, {1'b1, v}, 1'b1);
      repeat (100) @(negedge clk);
      await_val("core", b, 0);
      cpu_power_ok = 1'b1;
      repeat (4) @(negedge clk);
      cmd({3'h6, lfsr[9:8], 3'h6}, {1'b1, v}, 1'b1);
      await_val("ack", m[2] ? 7'h03 : 7'h00, 0);
      await_val("core", m[2] ? b : v, 1500);
      await_val("aux", m[2] ? b : v, 200);
      cpu_power_ok = 1'b0;
      await_val("core", b, 1500);
      core_in_reg = m[0];
      await_val("good", {6'h00, m[0]}, 20);
      enable = 1'b0;
      core_in_reg = 1'b1;
      await_val("good", 7'h00, 20);
    end
    cpu_power_ok = 1'b1;
    repeat (4) @(negedge clk);
    cmd({3'h5, 5'h06}, 8'h90, 1'b1);
    await_val("ack", 7'h03, 0);
    cmd({3'h6, 5'h07}, 8'h90, 1'b1);
    await_val("ack", 7'h03, 0);
    cmd({3'h6, 5'h06}, 8'h90, 1'b0);
    repeat (100) @(negedge clk);
    await_val("core", 7'h24, 0);
    cmd({3'h6, 5'h04}, 8'h30, 1'b1);
    await_val("core", 7'h30, 1500);
    await_val("aux", 7'h24, 0);
    await_val("hint", 7'h02, 0);
    cmd({3'h6, 5'h02}, 8'hff, 1'b1);
    await_val("aux", 7'h7f, 1500);
    await_val("good", 7'h01, 0);
    await_val("on", 7'h02, 0);
    cmd({3'h6, 5'h02}, 8'hb0, 1'b1);
    await_val("aux", 7'h30, 1500);
    await_val("on", 7'h03, 0);
    enable = 1'b0;
    type_select_line = 1'b1;
    repeat (4) @(negedge clk);
    enable = 1'b1;
    repeat (8) @(negedge clk);
    await_val("mode", 7'h00, 0);
    cmd({3'h6, 5'h06}, 8'h90, 1'b1);
    await_val("ack", 7'h03, 0);
    close_out();
  end
endmodule // test_serial_vid_slave_startup
